// ### core/spc_pkg.sv
// Package of constants for the stepper pulse input control block.
package spc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int INIT_TIME_US = 10;
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  localparam int INIT_CNT_W = 11;
  localparam int POS_W = 10;
  localparam int RES_W = 4;
  localparam int CUR_W = 3;
  localparam int ANALOG_W = 10;
  localparam int RATE_W = 10;
  localparam logic [RATE_W-1:0] RATE_MIN = 10'h001;
  localparam logic [RATE_W-1:0] RATE_MAX = 10'h3E8;
  localparam logic [ANALOG_W-1:0] ANALOG_FULL = 10'h3FF;
  localparam logic [POS_W-1:0] POS_ZERO = 10'h000;
  localparam logic [POS_W-1:0] STD_CYCLE_STEPS = 10'h014;
  localparam logic [RES_W-1:0] RES_DEFAULT = 4'hF;
  localparam logic [CUR_W-1:0] CUR_DEFAULT = 3'h7;
  localparam logic MODE_DEFAULT = 1'b1;
  localparam logic [CUR_W-1:0] CUR_LAST_VALID = 3'h2;
  localparam int LED_BLINK_CYCLES = 25000000;
  localparam int LED_CNT_W = 25;
endpackage : spc_pkg

// ### core/spc_rate_scale.sv
// Scales the analog current setting into an operating current rate.
`timescale 1ns/1ps
module spc_rate_scale #(
  parameter int ANALOG_W = spc_pkg::ANALOG_W,
  parameter int RATE_W = spc_pkg::RATE_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ANALOG_W-1:0] analog_in,
  output logic [RATE_W-1:0] rate_q
);
  logic [RATE_W+ANALOG_W-1:0] prod;
  logic [RATE_W-1:0] rate_d;

  always_comb begin
    prod = analog_in * spc_pkg::RATE_MAX;
    rate_d = RATE_W'(prod / spc_pkg::ANALOG_FULL);
    if (rate_d < spc_pkg::RATE_MIN) begin
      rate_d = spc_pkg::RATE_MIN;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rate_q <= spc_pkg::RATE_MIN;
    end else begin
      rate_q <= rate_d;
    end
  end
endmodule : spc_rate_scale

// ### core/spc_top.sv
// Step and direction pulse decoding, excitation gating and status outputs.
`timescale 1ns/1ps
// Function
// - Reset low de-energises, returns position to step zero, clears alarm.
// - Configuration sampled during reset, applied after initialisation ends.
// - Energise when enable low, both supplies present, no alarm, reset high, initialisation ended.
// - Ready output low only under the energise conditions, else released.
// - One-line mode: active edge steps, direction high clockwise, low counter.
// - Two-line mode: edge on one line steps only while other line low.
// - Operating current equals rated current times analog rate, 0.1 to 100 percent.
// - Alarm opens fault output, cuts excitation, blinks LED; reset clears it.
// - Origin output low when excitation position is step zero.
// - Position starts at step zero at power-up.
// - Status outputs are open-collector: pull low or release.
// - Supply indications may arrive or depart in any order.
// - Mode, resolution and rated current latched at power-up or reset rise; the code latches them when initialisation ends.
// - Mode select high picks one-line mode, low picks two-line mode.
module spc_top #(
  parameter int INIT_CYCLES = spc_pkg::INIT_CYCLES,
  parameter int LED_BLINK_CYCLES = spc_pkg::LED_BLINK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic control_supply_ok,
  input wire logic main_supply_ok,
  input wire logic enable_n,
  input wire logic forward_or_step_pulse_line,
  input wire logic reverse_or_direction_line,
  input wire logic pulse_mode_select,
  input wire logic [spc_pkg::RES_W-1:0] resolution_select,
  input wire logic high_res_variant,
  input wire logic [spc_pkg::CUR_W-1:0] rated_current_select,
  input wire logic [spc_pkg::ANALOG_W-1:0] run_current_analog,
  input wire logic fault_event,
  output logic excite_on,
  output logic step_pulse_out,
  output logic step_dir_cw,
  output logic [spc_pkg::POS_W-1:0] excite_position,
  output logic [spc_pkg::RES_W-1:0] active_resolution,
  output logic [spc_pkg::CUR_W-1:0] active_rated_current,
  output logic [spc_pkg::RATE_W-1:0] run_current_rate,
  output logic fault_output_o,
  output logic fault_output_oe_n,
  output logic pulse_accept_ready_o,
  output logic pulse_accept_ready_oe_n,
  output logic origin_phase_flag_o,
  output logic origin_phase_flag_oe_n,
  output logic power_fault_led
);
  typedef enum logic [1:0] {
    SPC_HELD = 2'b00,
    SPC_INIT = 2'b01,
    SPC_RUN = 2'b10
  } spc_state_type;

  spc_state_type state_q;
  logic [spc_pkg::INIT_CNT_W-1:0] init_cnt_q;
  logic mode_samp_q;
  logic [spc_pkg::RES_W-1:0] res_samp_q;
  logic [spc_pkg::CUR_W-1:0] cur_samp_q;
  logic mode_q;
  logic [spc_pkg::RES_W-1:0] res_q;
  logic [spc_pkg::CUR_W-1:0] cur_q;
  logic alarm_q;
  logic fwd_prev_q;
  logic rev_prev_q;
  logic [spc_pkg::POS_W-1:0] pos_q;
  logic step_q;
  logic dir_q;
  logic [spc_pkg::LED_CNT_W-1:0] led_cnt_q;
  logic led_q;
  logic fwd_rise;
  logic rev_rise;
  logic step_req;
  logic step_cw;
  logic ready;
  logic cur_bad;
  logic [spc_pkg::POS_W-1:0] cycle_steps;

  // Returns the number of steps in one electrical cycle for the standard or high-resolution variant.
  function automatic logic [spc_pkg::POS_W-1:0] cycle_len(input logic hr);
    cycle_len = hr ? spc_pkg::POS_W'(spc_pkg::STD_CYCLE_STEPS << 1) : spc_pkg::STD_CYCLE_STEPS;
  endfunction : cycle_len

  // Configuration sampling while reset is held and during initialisation.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= SPC_HELD;
      init_cnt_q <= '0;
    end else begin
      unique case (state_q)
        SPC_HELD: begin
          state_q <= SPC_INIT;
          init_cnt_q <= '0;
        end
        SPC_INIT: begin
          if (init_cnt_q == spc_pkg::INIT_CNT_W'(INIT_CYCLES - 1)) begin
            state_q <= SPC_RUN;
          end
          init_cnt_q <= init_cnt_q + 1'b1;
        end
        SPC_RUN: begin
          state_q <= SPC_RUN;
        end
        default: begin
          state_q <= SPC_HELD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (state_q != SPC_RUN) begin
      mode_samp_q <= pulse_mode_select;
      res_samp_q <= resolution_select;
      cur_samp_q <= rated_current_select;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_q <= spc_pkg::MODE_DEFAULT;
      res_q <= spc_pkg::RES_DEFAULT;
      cur_q <= spc_pkg::CUR_DEFAULT;
    end else if (state_q == SPC_INIT && init_cnt_q == spc_pkg::INIT_CNT_W'(INIT_CYCLES - 1)) begin
      mode_q <= mode_samp_q;
      res_q <= res_samp_q;
      cur_q <= cur_samp_q;
    end
  end

  // Rated current codes beyond the table raise the setting alarm.
  assign cur_bad = (state_q == SPC_RUN) && (cur_q[2] == 1'b0) && (cur_q < spc_pkg::CUR_LAST_VALID);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alarm_q <= 1'b0;
    end else if (fault_event || cur_bad) begin
      alarm_q <= 1'b1;
    end
  end

  // Both supplies are combined as plain levels so their order does not matter.
  assign ready = control_supply_ok && main_supply_ok && !alarm_q && !enable_n
                 && reset_n && (state_q == SPC_RUN);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fwd_prev_q <= 1'b0;
      rev_prev_q <= 1'b0;
    end else begin
      fwd_prev_q <= forward_or_step_pulse_line;
      rev_prev_q <= reverse_or_direction_line;
    end
  end

  assign fwd_rise = forward_or_step_pulse_line && !fwd_prev_q;
  assign rev_rise = reverse_or_direction_line && !rev_prev_q;

  always_comb begin
    step_req = 1'b0;
    step_cw = 1'b0;
    if (mode_q) begin
      step_req = fwd_rise;
      step_cw = reverse_or_direction_line;
    end else begin
      if (fwd_rise && !reverse_or_direction_line) begin
        step_req = 1'b1;
        step_cw = 1'b1;
      end else if (rev_rise && !forward_or_step_pulse_line) begin
        step_req = 1'b1;
        step_cw = 1'b0;
      end
    end
  end

  assign cycle_steps = cycle_len(high_res_variant);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pos_q <= spc_pkg::POS_ZERO;
    end else if (ready && step_req) begin
      if (step_cw) begin
        pos_q <= (pos_q == cycle_steps - 1'b1) ? spc_pkg::POS_ZERO : pos_q + 1'b1;
      end else begin
        pos_q <= (pos_q == spc_pkg::POS_ZERO) ? cycle_steps - 1'b1 : pos_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      step_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      step_q <= ready && step_req;
      if (ready && step_req) begin
        dir_q <= step_cw;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      led_cnt_q <= '0;
      led_q <= 1'b0;
    end else if (alarm_q) begin
      if (led_cnt_q == spc_pkg::LED_CNT_W'(LED_BLINK_CYCLES - 1)) begin
        led_cnt_q <= '0;
        led_q <= !led_q;
      end else begin
        led_cnt_q <= led_cnt_q + 1'b1;
      end
    end else begin
      led_cnt_q <= '0;
      led_q <= control_supply_ok;
    end
  end

  spc_rate_scale #(
    .ANALOG_W(spc_pkg::ANALOG_W),
    .RATE_W(spc_pkg::RATE_W)
  ) u_rate (
    .clk(clk),
    .reset_n(reset_n),
    .analog_in(run_current_analog),
    .rate_q(run_current_rate)
  );

  assign excite_on = ready;
  assign step_pulse_out = step_q;
  assign step_dir_cw = dir_q;
  assign excite_position = pos_q;
  assign active_resolution = res_q;
  assign active_rated_current = cur_q;
  assign power_fault_led = led_q;
  assign fault_output_o = 1'b0;
  assign fault_output_oe_n = alarm_q;
  assign pulse_accept_ready_o = 1'b0;
  assign pulse_accept_ready_oe_n = !ready;
  assign origin_phase_flag_o = 1'b0;
  assign origin_phase_flag_oe_n = (pos_q != spc_pkg::POS_ZERO);
endmodule : spc_top

// ### testbench/spc_properties.sv
// Port checker for the stepper pulse input control block.
`timescale 1ns/1ps
module spc_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable_n,
  input wire logic main_supply_ok,
  input wire logic forward_or_step_pulse_line,
  input wire logic reverse_or_direction_line,
  input wire logic fault_event,
  input wire logic excite_on,
  input wire logic step_pulse_out,
  input wire logic [spc_pkg::POS_W-1:0] excite_position,
  input wire logic fault_output_o,
  input wire logic fault_output_oe_n,
  input wire logic pulse_accept_ready_oe_n,
  input wire logic origin_phase_flag_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_idle;
    !pulse_accept_ready_oe_n && !forward_or_step_pulse_line && !reverse_or_direction_line;
  endsequence
  sequence s_rise;
    s_idle ##1 !pulse_accept_ready_oe_n && forward_or_step_pulse_line
      && !reverse_or_direction_line;
  endsequence
  property p_reset;
    disable iff (1'b0) !reset_n [*2] |-> !excite_on && !fault_output_oe_n
      && excite_position == spc_pkg::POS_ZERO;
  endproperty
  chk_reset_state:
    assert property (p_reset) else $error("reset state wrong");
  chk_step_rise:
    assert property (s_rise |=> step_pulse_out) else $error("no step");
  chk_step_cause:
    assert property ($changed(excite_position) |-> step_pulse_out) else $error("stray move");
  chk_pos_wrap:
    assert property (excite_position < 10'h028) else $error("position range");
  chk_excite_gate:
    assert property (excite_on |-> !enable_n && main_supply_ok && !fault_output_oe_n)
      else $error("bad excite");
  chk_ready_off:
    assert property ((enable_n || !main_supply_ok || fault_output_oe_n) [*2]
      |-> pulse_accept_ready_oe_n) else $error("bad ready");
  chk_origin_flag:
    assert property ($stable(excite_position) |-> origin_phase_flag_oe_n
      == (excite_position != spc_pkg::POS_ZERO)) else $error("bad origin");
  chk_fault_set:
    assert property (fault_event |-> ##[1:2] fault_output_oe_n && !fault_output_o)
      else $error("no alarm");
endmodule : spc_properties

// ### testbench/spc_host_model.sv
// Host model that drives the step and direction lines.
`timescale 1ns/1ps
module spc_host_model (
  input wire logic clk,
  input wire logic ready_oe_n,
  output logic fwd_line,
  output logic rev_line
);
  initial {fwd_line, rev_line} = 2'h0;
  task automatic pulse(input logic two, cw, both, unsafe);
    if (unsafe || ready_oe_n === 1'b0) begin
      rev_line = !two && cw;
      repeat (40) @(posedge clk);
      #1 fwd_line = !two || cw || both;
      rev_line = two ? !cw || both : rev_line;
      repeat (40) @(posedge clk);
      #1 {fwd_line, rev_line} = 2'h0;
      repeat (40) @(posedge clk);
      #1;
    end
  endtask : pulse
endmodule : spc_host_model

// ### testbench/spc_top_bench.sv
// Self-checking bench for the stepper pulse input control block.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module spc_top_bench;
  typedef struct {logic m; logic cw; logic both; int d;} spc_row_type;
  logic clk, reset_n, control_supply_ok, main_supply_ok, enable_n, lm;
  logic forward_or_step_pulse_line, reverse_or_direction_line, pulse_mode_select;
  logic high_res_variant, fault_event, excite_on, step_pulse_out, step_dir_cw;
  logic fault_output_oe_n, pulse_accept_ready_oe_n, origin_phase_flag_oe_n, power_fault_led;
  logic [2:0] active_rated_current;
  logic [3:0] resolution_select, active_resolution;
  logic [2:0] rated_current_select;
  logic [9:0] run_current_analog, run_current_rate, excite_position;
  int n_tests, n_mismatch, cyc, p;
  spc_row_type rows[7] = '{'{1'b1, 1'b0, 1'b0, -1}, '{1'b1, 1'b1, 1'b0, 1},
    '{1'b1, 1'b1, 1'b0, 1}, '{1'b0, 1'b1, 1'b0, 1}, '{1'b0, 1'b0, 1'b0, -1},
    '{1'b0, 1'b1, 1'b1, 0}, '{1'b0, 1'b0, 1'b1, 0}};
  spc_top #(.INIT_CYCLES(4), .LED_BLINK_CYCLES(8)) i_spc_top (.clk, .reset_n,
    .control_supply_ok, .main_supply_ok, .enable_n, .forward_or_step_pulse_line,
    .reverse_or_direction_line, .pulse_mode_select, .resolution_select, .high_res_variant,
    .rated_current_select, .run_current_analog, .fault_event, .excite_on, .step_pulse_out,
    .step_dir_cw, .excite_position, .active_resolution, .active_rated_current,
    .run_current_rate, .fault_output_o(), .fault_output_oe_n, .pulse_accept_ready_o(),
    .pulse_accept_ready_oe_n, .origin_phase_flag_o(), .origin_phase_flag_oe_n,
    .power_fault_led);
  spc_host_model i_spc_host_model (.clk, .ready_oe_n(pulse_accept_ready_oe_n),
    .fwd_line(forward_or_step_pulse_line), .rev_line(reverse_or_direction_line));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic do_reset(input logic m, input logic [3:0] r);
    @(posedge clk) #1 reset_n = 1'b0;
    pulse_mode_select = m;
    resolution_select = r;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (8) @(posedge clk);
    #1 p = 0;
    `CHK("pos0", 10'h000, excite_position)
  endtask : do_reset
  initial begin
    {reset_n, fault_event, high_res_variant, enable_n, lm} = 5'h1;
    {control_supply_ok, main_supply_ok, pulse_mode_select} = 3'h7;
    resolution_select = 4'hF;
    rated_current_select = 3'h7;
    run_current_analog = 10'h000;
    do_reset(1'b1, 4'hF);
    foreach (rows[i]) begin
      if (rows[i].m !== lm) do_reset(rows[i].m, 4'hF);
      lm = rows[i].m;
      i_spc_host_model.pulse(!rows[i].m, rows[i].cw, rows[i].both, 1'b0);
      p = (p + rows[i].d + 20) % 20;
      `CHK("pos", 10'(p), excite_position)
      `CHK("tim", p != 0, origin_phase_flag_oe_n)
      if (rows[i].d != 0) `CHK("dir", rows[i].cw, step_dir_cw)
    end
    $display("test rows done");
    enable_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 `CHK("rdy", 1'b1, pulse_accept_ready_oe_n)
    `CHK("exc", 1'b0, excite_on)
    i_spc_host_model.pulse(1'b1, 1'b1, 1'b0, 1'b1);
    `CHK("nostep", 10'(p), excite_position)
    enable_n = 1'b0;
    `CHK("rate0", 10'h001, run_current_rate)
    run_current_analog = 10'h3FF;
    repeat (4) @(posedge clk);
    #1 `CHK("rate1", 10'h3E8, run_current_rate)
    do_reset(1'b1, 4'h3);
    resolution_select = 4'h5;
    repeat (4) @(posedge clk);
    #1 `CHK("res", 4'h3, active_resolution)
    `CHK("led1", 1'b1, power_fault_led)
    high_res_variant = 1'b1;
    i_spc_host_model.pulse(1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("hr", 10'h027, excite_position)
    high_res_variant = 1'b0;
    fault_event = 1'b1;
    @(posedge clk) #1 fault_event = 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK("alm", 1'b1, fault_output_oe_n)
    `CHK("almexc", 1'b0, excite_on)
    repeat (5) @(posedge clk);
    #1 `CHK("led", 1'b0, power_fault_led)
    rated_current_select = 3'h0;
    do_reset(1'b1, 4'hF);
    `CHK("cur", 3'h0, active_rated_current)
    `CHK("curalm", 1'b1, fault_output_oe_n)
    rated_current_select = 3'h7;
    do_reset(1'b1, 4'hF);
    `CHK("clr", 1'b0, fault_output_oe_n)
    $display("test cases done");
    results();
  end
endmodule : spc_top_bench
bind spc_top spc_properties i_spc_properties (.clk, .reset_n, .enable_n, .main_supply_ok,
  .forward_or_step_pulse_line, .reverse_or_direction_line, .fault_event, .excite_on,
  .step_pulse_out, .excite_position, .fault_output_o, .fault_output_oe_n,
  .pulse_accept_ready_oe_n, .origin_phase_flag_oe_n);
